// ===== hw/spu_defines.vh
// constants for the serial port unit: register offsets, fields, resets
// assumes byte addresses on a 32-bit apb bus, one register per word
`ifndef SPU_DEFINES_VH
`define SPU_DEFINES_VH

`define SPU_OFS_MODE        8'h00
`define SPU_OFS_DIVISOR     8'h04
`define SPU_OFS_TX_BUFFER   8'h08
`define SPU_OFS_RX_BUFFER   8'h0C
`define SPU_OFS_RX_ERROR    8'h10
`define SPU_OFS_TX_STATUS   8'h14

// port_mode_reg fields
`define SPU_MODE_POWER      7
`define SPU_MODE_TX_EN      6
`define SPU_MODE_RX_EN      5
`define SPU_MODE_PAR_HI     4
`define SPU_MODE_PAR_LO     3
`define SPU_MODE_LEN8       2
`define SPU_MODE_STOP2      1
`define SPU_MODE_MERGE      0

// parity codes
`define SPU_PAR_NONE        2'h0
`define SPU_PAR_ZERO        2'h1
`define SPU_PAR_ODD         2'h2
`define SPU_PAR_EVEN        2'h3

// rx_error_status_reg fields
`define SPU_ERR_PARITY      2
`define SPU_ERR_FRAMING     1
`define SPU_ERR_OVERRUN     0

// tx_status_reg fields
`define SPU_STAT_FULL       1
`define SPU_STAT_SHIFTING   0

`define SPU_RST_MODE        8'h05
`define SPU_RST_DIVISOR     8'h20
`define SPU_RST_RX_BUFFER   8'hFF

`endif

// ===== hw/spu_serial_port_unit.v
// serial_port_unit: double-buffered uart transmitter, receiver with
// parity, framing and overrun errors, and an apb register slave.
// assumes i_ref_clk is the base clock; one bit lasts 2*k clocks.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "spu_defines.vh"
`default_nettype none

module spu_serial_port_unit (
    input  wire        i_ref_clk,
    input  wire        i_reset_n,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire        i_serial_in_pin,
    output reg         o_serial_out_pin,
    output reg         o_tx_done_irq,
    output reg         o_rx_done_irq,
    output reg         o_rx_error_irq
);
    localparam [1:0] TX_IDLE  = 2'b01;
    localparam [1:0] TX_SHIFT = 2'b10;
    localparam [2:0] RX_IDLE  = 3'b001;
    localparam [2:0] RX_START = 3'b010;
    localparam [2:0] RX_DATA  = 3'b100;

    reg [7:0]  port_mode_reg;
    reg [7:0]  baud_divisor_reg;
    reg [7:0]  tx_buffer;
    reg [7:0]  rx_buffer;
    reg [2:0]  rx_error_status_reg;
    reg        tx_buffer_full_flag;
    reg        tx_shifting_flag;
    reg        rx_unread;
    reg [2:0]  read_err_snap;
    reg [1:0]  tx_state;
    reg [11:0] tx_shift_reg;
    reg [3:0]  tx_bits_left;
    reg [8:0]  tx_cnt;
    reg [2:0]  rx_state;
    reg [8:0]  rx_cnt;
    reg [3:0]  rx_idx;
    reg [7:0]  rx_shift_reg;
    reg        rx_par_bit;
    reg        rx_meta;
    reg        rx_sync;
    reg        rx_prev;
    wire       power   = port_mode_reg[`SPU_MODE_POWER];
    wire       tx_on   = power & port_mode_reg[`SPU_MODE_TX_EN];
    wire       rx_on   = power & port_mode_reg[`SPU_MODE_RX_EN];
    wire       len8    = port_mode_reg[`SPU_MODE_LEN8];
    wire       stop2   = port_mode_reg[`SPU_MODE_STOP2];
    wire       merge   = port_mode_reg[`SPU_MODE_MERGE];
    wire [1:0] par     = port_mode_reg[`SPU_MODE_PAR_HI:`SPU_MODE_PAR_LO];
    wire [3:0] len     = len8 ? 4'h8 : 4'h7;
    wire       has_par = (par != `SPU_PAR_NONE);
    wire [8:0] half_bit = {1'b0, baud_divisor_reg} - 9'h001;
    wire [8:0] full_bit = {baud_divisor_reg, 1'b0} - 9'h001;
    wire       setup   = i_psel & ~i_penable;
    wire       access  = i_psel & i_penable & o_pready;
    wire       wr      = access & i_pwrite;
    wire       rd      = access & ~i_pwrite;
    // data bits masked to the character length
    function [7:0] spu_mask;
        input [7:0] d;
        input       l8;
        begin
            spu_mask = l8 ? d : {1'b0, d[6:0]};
        end
    endfunction
    // parity bit to send, or expected for even/odd reception
    function spu_parity;
        input [7:0] d;
        input [1:0] p;
        begin
            case (p)
                `SPU_PAR_ODD:  spu_parity = ~(^d);
                `SPU_PAR_EVEN: spu_parity = ^d;
                default:       spu_parity = 1'b0;
            endcase
        end
    endfunction
    // start, data lsb first, optional parity; stop bits are the ones above
    reg [11:0] tx_frame;
    reg [7:0]  tx_data;
    integer    i;
    always @* begin
        tx_data  = spu_mask(tx_buffer, len8);
        tx_frame = 12'hFFF;
        tx_frame[0] = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            if (i < len) begin
                tx_frame[i + 1] = tx_data[i];
            end
        end
        if (has_par) begin
            tx_frame[len + 4'h1] = spu_parity(tx_data, par);
        end
    end
    wire [3:0] tx_count = 4'h1 + len + {3'h0, has_par} + (stop2 ? 4'h2 : 4'h1);
    // register read value, captured in the setup cycle
    reg [31:0] next_prdata;
    reg        next_slverr;
    always @* begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (i_paddr)
            `SPU_OFS_MODE:      next_prdata[7:0] = port_mode_reg;
            `SPU_OFS_DIVISOR:   next_prdata[7:0] = baud_divisor_reg;
            `SPU_OFS_TX_BUFFER: next_prdata[7:0] = tx_buffer;
            `SPU_OFS_RX_BUFFER: next_prdata[7:0] = rx_buffer;
            `SPU_OFS_RX_ERROR:  next_prdata[2:0] = rx_error_status_reg;
            `SPU_OFS_TX_STATUS: next_prdata[1:0] =
                {tx_buffer_full_flag, tx_shifting_flag};
            default:            next_slverr = 1'b1;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata         <= 32'h0000_0000;
            o_pready         <= 1'b0;
            o_pslverr        <= 1'b0;
            port_mode_reg    <= `SPU_RST_MODE;
            baud_divisor_reg <= `SPU_RST_DIVISOR;
            read_err_snap    <= 3'h0;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & next_slverr;
            if (setup) begin
                o_prdata      <= next_prdata;
                read_err_snap <= rx_error_status_reg;
            end
            if (wr && i_paddr == `SPU_OFS_MODE) begin
                port_mode_reg <= i_pwdata[7:0];
            end
            if (wr && i_paddr == `SPU_OFS_DIVISOR) begin
                baud_divisor_reg <= i_pwdata[7:0];
            end
        end
    end
    // transmitter
    wire tx_bit_end = (tx_state == TX_SHIFT) && (tx_cnt == full_bit);
    wire tx_last    = tx_bit_end && (tx_bits_left == 4'h1);
    wire tx_load    = tx_buffer_full_flag &&
                      ((tx_state == TX_IDLE) || tx_last);
    wire tx_write   = wr && (i_paddr == `SPU_OFS_TX_BUFFER) && tx_on;

    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_state            <= TX_IDLE;
            tx_buffer           <= 8'h00;
            tx_buffer_full_flag <= 1'b0;
            tx_shifting_flag    <= 1'b0;
            tx_shift_reg        <= 12'hFFF;
            tx_bits_left        <= 4'h0;
            tx_cnt              <= 9'h000;
            o_serial_out_pin    <= 1'b1;
            o_tx_done_irq       <= 1'b0;
        end else if (!tx_on) begin
            tx_state            <= TX_IDLE;
            tx_buffer_full_flag <= 1'b0;
            tx_shifting_flag    <= 1'b0;
            tx_cnt              <= 9'h000;
            o_serial_out_pin    <= 1'b1;
            o_tx_done_irq       <= 1'b0;
        end else begin
            o_tx_done_irq <= tx_last;
            if (tx_write) begin
                tx_buffer           <= i_pwdata[7:0];
                tx_buffer_full_flag <= 1'b1;
            end else if (tx_load) begin
                tx_buffer_full_flag <= 1'b0;
            end
            case (tx_state)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_state         <= TX_SHIFT;
                        tx_shifting_flag <= 1'b1;
                        tx_shift_reg     <= tx_frame;
                        tx_bits_left     <= tx_count;
                        tx_cnt           <= 9'h000;
                        o_serial_out_pin <= tx_frame[0];
                    end
                end
                TX_SHIFT: begin
                    if (tx_load) begin
                        // back to back: next start bit follows the stop
                        tx_shift_reg     <= tx_frame;
                        tx_bits_left     <= tx_count;
                        tx_cnt           <= 9'h000;
                        o_serial_out_pin <= tx_frame[0];
                    end else if (tx_last) begin
                        tx_state         <= TX_IDLE;
                        tx_shifting_flag <= 1'b0;
                        o_serial_out_pin <= 1'b1;
                    end else if (tx_bit_end) begin
                        tx_cnt           <= 9'h000;
                        tx_bits_left     <= tx_bits_left - 4'h1;
                        tx_shift_reg     <= {1'b1, tx_shift_reg[11:1]};
                        o_serial_out_pin <= tx_shift_reg[1];
                    end else begin
                        tx_cnt <= tx_cnt + 9'h001;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
    // receiver
    wire rx_sample  = (rx_state == RX_DATA) && (rx_cnt == full_bit);
    wire rx_is_stop = rx_idx == (len + {3'h0, has_par});
    wire rx_finish  = rx_sample && rx_is_stop;
    wire [7:0] rx_data = spu_mask(rx_shift_reg, len8);
    wire par_bad    = ((par == `SPU_PAR_ODD) || (par == `SPU_PAR_EVEN)) &&
                      (rx_par_bit != spu_parity(rx_data, par));
    wire [2:0] rx_new_err = {par_bad, ~rx_sync, rx_unread};
    wire rd_buf = rd && (i_paddr == `SPU_OFS_RX_BUFFER);
    wire rd_err = rd && (i_paddr == `SPU_OFS_RX_ERROR);

    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= i_serial_in_pin;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_state            <= RX_IDLE;
            rx_cnt              <= 9'h000;
            rx_idx              <= 4'h0;
            rx_shift_reg        <= 8'h00;
            rx_par_bit          <= 1'b0;
            rx_buffer           <= `SPU_RST_RX_BUFFER;
            rx_unread           <= 1'b0;
            rx_error_status_reg <= 3'h0;
            o_rx_done_irq       <= 1'b0;
            o_rx_error_irq      <= 1'b0;
        end else if (!power) begin
            rx_state            <= RX_IDLE;
            rx_cnt              <= 9'h000;
            rx_buffer           <= `SPU_RST_RX_BUFFER;
            rx_unread           <= 1'b0;
            rx_error_status_reg <= 3'h0;
            o_rx_done_irq       <= 1'b0;
            o_rx_error_irq      <= 1'b0;
        end else begin
            o_rx_done_irq  <= rx_finish &&
                              (merge || rx_new_err == 3'h0);
            o_rx_error_irq <= rx_finish && !merge &&
                              (rx_new_err != 3'h0);
            // a read clears only what it returned; new errors win
            rx_error_status_reg <= (rx_error_status_reg &
                ~(rd_err ? read_err_snap : 3'h0)) |
                (rx_finish ? rx_new_err : 3'h0);
            if (rx_finish && !rx_unread) begin
                rx_buffer <= rx_data;
                rx_unread <= 1'b1;
            end else if (rd_buf) begin
                rx_unread <= 1'b0;
            end
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= 9'h000;
                    if (rx_on && rx_prev && !rx_sync) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (!rx_on) begin
                        rx_state <= RX_IDLE;
                    end else if (rx_cnt == half_bit) begin
                        rx_cnt   <= 9'h000;
                        rx_idx   <= 4'h0;
                        rx_state <= rx_sync ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt <= rx_cnt + 9'h001;
                    end
                end
                RX_DATA: begin
                    if (!rx_on) begin
                        rx_state <= RX_IDLE;
                    end else if (rx_sample) begin
                        rx_cnt <= 9'h000;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx < len) begin
                            rx_shift_reg[rx_idx[2:0]] <= rx_sync;
                        end else if (!rx_is_stop) begin
                            rx_par_bit <= rx_sync;
                        end else begin
                            rx_state <= RX_IDLE;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 9'h001;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== sim/spu_serial_port_unit_asserts.sv
// port checker for the serial port unit
// assumes a divisor of at least 8, so one bit lasts 16 clocks or more
`timescale 1ns/1ps
`default_nettype none
module spu_asserts (
    input wire logic        i_ref_clk,
    input wire logic        i_reset_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_serial_out_pin,
    input wire logic        o_tx_done_irq,
    input wire logic        o_rx_done_irq,
    input wire logic        o_rx_error_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    AST_PREADY_NEXT:
        assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    AST_PREADY_PULSE:
        assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    AST_SLVERR_MAP:
        assert property (o_pready && i_paddr[1:0] == 2'h0
            |-> o_pslverr == (i_paddr > 8'h14))
        else $error("slave error does not match map");
    AST_STATUS_UPPER:
        assert property (o_pready && !i_pwrite && i_paddr == 8'h14
            |-> o_prdata[31:2] == 30'h0)
        else $error("status upper bits set");
    AST_TX_DONE_STOP:
        assert property (o_tx_done_irq
            |-> $past(o_serial_out_pin) && $past(o_serial_out_pin, 2))
        else $error("tx done without stop level");
    AST_TX_DONE_SPACED:
        assert property (o_tx_done_irq |=> !o_tx_done_irq [*8])
        else $error("tx done pulses too close");
    AST_START_WIDTH:
        assert property ($fell(o_serial_out_pin)
            |=> !o_serial_out_pin [*8])
        else $error("start bit too short");
    AST_RX_ONE_IRQ:
        assert property (!(o_rx_done_irq && o_rx_error_irq))
        else $error("both receive irqs at once");
    AST_RX_SPACED:
        assert property (o_rx_done_irq || o_rx_error_irq
            |=> !(o_rx_done_irq || o_rx_error_irq) [*8])
        else $error("receive irqs too close");
endmodule
bind spu_serial_port_unit spu_asserts i_spu_asserts (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_serial_out_pin(o_serial_out_pin), .o_tx_done_irq(o_tx_done_irq),
    .o_rx_done_irq(o_rx_done_irq), .o_rx_error_irq(o_rx_error_irq)
);
`default_nettype wire

// ===== sim/spu_remote_node.sv
// remote serial node: sends frames to the port, collects its frames
// assumes 8 data bits, a parity bit and one stop bit each way
`timescale 1ns/1ps
`default_nettype none
module spu_remote_node #(parameter int BIT_CLKS = 16) (
    input  wire logic i_clk,
    input  wire logic i_tx_line,
    output var  logic o_rx_line
);
    logic [9:0] frame;
    logic [9:0] got_q[$];
    initial o_rx_line = 1'b1;
    task send(input logic [7:0] d, input logic par, input logic stop);
        logic [10:0] bits;
        bits = {stop, par, d, 1'b0};
        @(posedge i_clk);
        for (int i = 0; i < 11; i++) begin
            o_rx_line <= bits[i];
            repeat (BIT_CLKS) @(posedge i_clk);
        end
        o_rx_line <= 1'b1;
    endtask
    task glitch(input int len);
        @(posedge i_clk);
        o_rx_line <= 1'b0;
        repeat (len) @(posedge i_clk);
        o_rx_line <= 1'b1;
        // idle long enough that the receiver has to reject the pulse
        repeat (2 * BIT_CLKS) @(posedge i_clk);
    endtask
    // samples mid-bit: data, parity, stop
    initial forever begin
        @(negedge i_tx_line);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            frame[i] = i_tx_line;
        end
        got_q.push_back(frame);
    end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the serial port unit
// assumes the remote node model and the port checker are compiled first
`timescale 1ns/1ps
`include "spu_defines.vh"
`default_nettype none
module tb;
    logic        i_ref_clk;
    logic        i_reset_n;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    wire  [31:0] o_prdata;
    wire         o_pready;
    wire         o_pslverr;
    wire         rx_line;
    wire         o_serial_out_pin;
    wire         o_tx_done_irq;
    wire         o_rx_done_irq;
    wire         o_rx_error_irq;
    logic        slverr;
    logic [31:0] q;
    int          errors, comparisons, cycles, txd, rxd, rxe;
    int          t_last, t_gap, n;
    spu_serial_port_unit i_spu_serial_port_unit (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_serial_in_pin(rx_line),
        .o_serial_out_pin(o_serial_out_pin), .o_tx_done_irq(o_tx_done_irq),
        .o_rx_done_irq(o_rx_done_irq), .o_rx_error_irq(o_rx_error_irq));
    spu_remote_node #(.BIT_CLKS(16)) i_spu_remote_node (.i_clk(i_ref_clk),
        .i_tx_line(o_serial_out_pin), .o_rx_line(rx_line));
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cycles++;
        rxd += int'(o_rx_done_irq === 1'b1);
        rxe += int'(o_rx_error_irq === 1'b1);
        if (o_tx_done_irq === 1'b1) begin
            txd++;
            t_gap = cycles - t_last;
            t_last = cycles;
        end
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            k++;
        end while (o_pready !== 1'b1);
        q = o_prdata;
        slverr = o_pslverr;
        chk("apb access cycles", 32'h1, 32'(k));
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask
    task rx_case(input logic [7:0] d, input logic par, input logic stop,
                 input int exp_done, input int exp_err);
        int a, b;
        a = rxd;
        b = rxe;
        i_spu_remote_node.send(d, par, stop);
        for (n = 0; n < 64 && rxd == a && rxe == b; n++) @(posedge i_ref_clk);
        repeat (2) @(posedge i_ref_clk);
        chk("rx done pulses", 32'(exp_done), 32'(rxd - a));
        chk("rx error pulses", 32'(exp_err), 32'(rxe - b));
    endtask
    task t_reset;
        rd("mode", `SPU_OFS_MODE, 32'h5);
        rd("divisor", `SPU_OFS_DIVISOR, 32'h20);
        rd("rx buffer", `SPU_OFS_RX_BUFFER, 32'hFF);
        rd("rx errors", `SPU_OFS_RX_ERROR, 32'h0);
        rd("tx status", `SPU_OFS_TX_STATUS, 32'h0);
        rd("unmapped data", 8'h40, 32'h0);
        chk("unmapped slverr", 32'h1, 32'(slverr));
    endtask
    task t_cont_tx;
        apb(1'b1, `SPU_OFS_DIVISOR, 32'h8);
        apb(1'b1, `SPU_OFS_MODE, 32'hFC);
        apb(1'b1, `SPU_OFS_TX_BUFFER, 32'hA5);
        rd("status shifting", `SPU_OFS_TX_STATUS, 32'h1);
        apb(1'b1, `SPU_OFS_TX_BUFFER, 32'h3C);
        rd("status full", `SPU_OFS_TX_STATUS, 32'h3);
        for (n = 0; n < 400 && txd < 1; n++) @(posedge i_ref_clk);
        rd("status next", `SPU_OFS_TX_STATUS, 32'h1);
        for (n = 0; n < 400 && txd < 2; n++) @(posedge i_ref_clk);
        rd("status idle", `SPU_OFS_TX_STATUS, 32'h0);
        chk("frame spacing", 32'd176, 32'(t_gap));
        chk("frames seen", 32'h2, 32'(i_spu_remote_node.got_q.size()));
        chk("frame 1", {22'h1, ^8'hA5, 8'hA5},
            32'(i_spu_remote_node.got_q[0]));
        chk("frame 2", {22'h1, ^8'h3C, 8'h3C},
            32'(i_spu_remote_node.got_q[1]));
    endtask
    task t_rx;
        apb(1'b1, `SPU_OFS_MODE, 32'hDC);
        rx_case(8'h5A, ^8'h5A, 1'b1, 0, 0);
        apb(1'b1, `SPU_OFS_MODE, 32'hFC);
        i_spu_remote_node.glitch(4);
        rx_case(8'h5A, ^8'h5A, 1'b1, 1, 0);
        rd("no errors", `SPU_OFS_RX_ERROR, 32'h0);
        rd("rx byte", `SPU_OFS_RX_BUFFER, 32'h5A);
        rx_case(8'hC3, ~^8'hC3, 1'b1, 0, 1);
        rd("parity flag", `SPU_OFS_RX_ERROR, 32'h4);
        rd("cleared", `SPU_OFS_RX_ERROR, 32'h0);
        rd("parity byte", `SPU_OFS_RX_BUFFER, 32'hC3);
        rx_case(8'h81, ^8'h81, 1'b0, 0, 1);
        rd("framing flag", `SPU_OFS_RX_ERROR, 32'h2);
        rd("framing byte", `SPU_OFS_RX_BUFFER, 32'h81);
        rx_case(8'h11, ^8'h11, 1'b1, 1, 0);
        rx_case(8'h22, ^8'h22, 1'b1, 0, 1);
        rd("overrun flag", `SPU_OFS_RX_ERROR, 32'h1);
        rd("kept byte", `SPU_OFS_RX_BUFFER, 32'h11);
        apb(1'b1, `SPU_OFS_MODE, 32'hFD);
        rx_case(8'hC3, ~^8'hC3, 1'b1, 1, 0);
        rd("merged flag", `SPU_OFS_RX_ERROR, 32'h4);
        rd("merged byte", `SPU_OFS_RX_BUFFER, 32'hC3);
        apb(1'b1, `SPU_OFS_MODE, 32'hFE);
        rx_case(8'h11, ^8'h11, 1'b1, 1, 0);
        rd("two stop byte", `SPU_OFS_RX_BUFFER, 32'h11);
        apb(1'b1, `SPU_OFS_MODE, 32'hF4);
        rx_case(8'h5A, ~^8'h5A, 1'b1, 1, 0);
        rd("odd no errors", `SPU_OFS_RX_ERROR, 32'h0);
        rd("odd byte", `SPU_OFS_RX_BUFFER, 32'h5A);
    endtask
    initial begin
        i_reset_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        repeat (12) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_cont_tx();
        t_rx();
        tally_and_finish();
    end
endmodule
`default_nettype wire
